// [hw/i2cse_slave.sv]
`timescale 1ns/1ps
`include "i2cse_defs.svh"
module i2cse_slave
  import i2cse_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Module software reset, synchronous level
  input wire logic sw_reset,
  // Bus pins, split into in / out / enable
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Configuration
  input wire logic [1:0] serial_mode_select,
  input wire logic synchronous_mode_bit,
  input wire logic master_select,
  input wire logic [9:0] own_address_zero,
  input wire logic own_address_ten_bit,
  input wire logic general_call_respond,
  // Direction status and its software clear
  output logic transmit_direction,
  input wire logic transmit_direction_clear,
  // Flags and their clears
  output logic start_match_flag,
  input wire logic start_match_clear,
  output logic stop_detect_flag,
  input wire logic stop_detect_clear,
  output logic transmit_request_flag,
  output logic receive_flag,
  // Transmit buffer write port
  input wire logic [7:0] transmit_buffer_data,
  input wire logic transmit_buffer_write,
  // Receive buffer read port
  output logic [7:0] receive_buffer,
  input wire logic receive_buffer_read,
  // NACK request: set pulse in, pending level out
  input wire logic nack_request_set,
  output logic nack_request
);
  // Synchronised and delayed pin levels
  logic scl_q, sda_q, scl_d, sda_d;
  // Engine state
  i2cse_state_e state;
  i2cse_phase_e phase;
  logic [3:0] cnt;        // Bit counter within a byte
  logic [7:0] sh;         // Shared shift register
  logic [7:0] tx_buf;     // Transmit holding buffer
  logic tx_full;          // Holding buffer has a byte
  logic drive_low;        // Pull SDA low
  logic acking;           // Current ninth bit is an ACK
  logic tx_mode;          // Addressed for reading
  logic master_ack;       // Master acknowledged last byte
  logic selected;         // Addressed since last stop
  logic ten_matched;      // Full ten-bit address seen
  // One-cycle event pulses towards the flag logic
  logic ev_match_rd, ev_match_wr, ev_move, ev_rx_load, ev_stop, ev_nack_sent;

  // Both pins pass two flops before any logic looks at them
  i2cse_sync #(.W(2)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({scl_in, sda_in}),
    .q({scl_q, sda_q})
  );

  // Previous synchronised levels for edge finding
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  // Bus events
  logic scl_rise, scl_fall, start_cond, stop_cond, active;
  assign scl_rise = scl_q & ~scl_d;
  assign scl_fall = ~scl_q & scl_d;
  assign start_cond = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_cond = scl_q & scl_d & ~sda_d & sda_q;
  // Slave only works in I2C mode, synchronous, not master
  assign active = (serial_mode_select == `I2CSE_MODE_I2C) & synchronous_mode_bit & ~master_select & ~sw_reset;

  // Address compares on the just-received byte
  logic hit7, hit10, gc_hit;
  assign hit7 = ~own_address_ten_bit & (sh[7:1] == own_address_zero[6:0]);
  assign hit10 = own_address_ten_bit & (sh[7:3] == `I2CSE_TEN_PREFIX)
                 & (sh[2:1] == own_address_zero[9:8]);
  assign gc_hit = general_call_respond & (sh == `I2CSE_GC_BYTE);

  // Stretching pulls SCL low only; scl_oe is decoded from state, so a state change releases it in the same cycle
  assign scl_out = 1'b0;
  assign scl_oe = (state == I2CSE_WAIT_ADR) | (state == I2CSE_WAIT_TX) | (state == I2CSE_WAIT_RX);
  // SDA likewise only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;

  // Main engine: bit timing, address decode, buffers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= I2CSE_IDLE;
      phase <= I2CSE_ADDR1;
      cnt <= `I2CSE_RST_CNT;
      sh <= `I2CSE_RST_BYTE;
      tx_buf <= `I2CSE_RST_BYTE;
      tx_full <= 1'b0;
      receive_buffer <= `I2CSE_RST_BYTE;
      drive_low <= 1'b0;
      acking <= 1'b0;
      tx_mode <= 1'b0;
      master_ack <= 1'b0;
      selected <= 1'b0;
      ten_matched <= 1'b0;
      ev_match_rd <= 1'b0;
      ev_match_wr <= 1'b0;
      ev_move <= 1'b0;
      ev_rx_load <= 1'b0;
      ev_stop <= 1'b0;
      ev_nack_sent <= 1'b0;
    end else begin
      ev_match_rd <= 1'b0;
      ev_match_wr <= 1'b0;
      ev_move <= 1'b0;
      ev_rx_load <= 1'b0;
      ev_stop <= 1'b0;
      ev_nack_sent <= 1'b0;
      // Software writes land in the holding buffer at any time
      if (transmit_buffer_write) begin
        tx_buf <= transmit_buffer_data;
        tx_full <= 1'b1;
      end
      if (!active) begin
        // Disabled: off the bus, forget any addressing
        state <= I2CSE_IDLE;
        drive_low <= 1'b0;
        selected <= 1'b0;
        ten_matched <= 1'b0;
      end else if (start_cond) begin
        // Start or restart: back to taking in an address
        state <= I2CSE_RECV;
        phase <= I2CSE_ADDR1;
        cnt <= `I2CSE_RST_CNT;
        drive_low <= 1'b0;
      end else if (stop_cond) begin
        // Stop ends the frame; flag only if we took part
        ev_stop <= selected;
        state <= I2CSE_IDLE;
        drive_low <= 1'b0;
        selected <= 1'b0;
        ten_matched <= 1'b0;
      end else begin
        case (state)
          I2CSE_RECV: begin
            if (scl_rise) begin
              // Sample on the rising edge, MSB first
              sh <= {sh[6:0], sda_q};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == `I2CSE_BYTE_BITS) begin
              cnt <= `I2CSE_RST_CNT;
              case (phase)
                I2CSE_ADDR1: begin
                  if (gc_hit || (hit7 && !sh[0])) begin
                    // Write match: receive with automatic ACK
                    ev_match_wr <= 1'b1;
                    selected <= 1'b1;
                    tx_mode <= 1'b0;
                    phase <= I2CSE_DATA;
                    acking <= 1'b1;
                    drive_low <= 1'b1;
                    state <= I2CSE_ACK;
                  end else if ((hit7 || (hit10 && ten_matched)) && sh[0]) begin
                    // Read match: wait for a fresh byte before the ACK
                    ev_match_rd <= 1'b1;
                    selected <= 1'b1;
                    tx_mode <= 1'b1;
                    tx_full <= transmit_buffer_write;
                    state <= I2CSE_WAIT_ADR;
                  end else if (hit10 && !sh[0]) begin
                    // First ten-bit byte: ACK and take the low byte
                    phase <= I2CSE_ADDR2;
                    acking <= 1'b1;
                    drive_low <= 1'b1;
                    state <= I2CSE_ACK;
                  end else begin
                    // Not us: stay off the bus until next start
                    state <= I2CSE_IDLE;
                  end
                end
                I2CSE_ADDR2: begin
                  if (sh == own_address_zero[7:0]) begin
                    // Full ten-bit address: receiver mode
                    ev_match_wr <= 1'b1;
                    ten_matched <= 1'b1;
                    selected <= 1'b1;
                    tx_mode <= 1'b0;
                    phase <= I2CSE_DATA;
                    acking <= 1'b1;
                    drive_low <= 1'b1;
                    state <= I2CSE_ACK;
                  end else begin
                    state <= I2CSE_IDLE;
                  end
                end
                default: begin
                  if (nack_request) begin
                    // Requested NACK wins even over a full buffer
                    receive_buffer <= sh;
                    ev_rx_load <= 1'b1;
                    ev_nack_sent <= 1'b1;
                    acking <= 1'b0;
                    drive_low <= 1'b0;
                    state <= I2CSE_ACK;
                  end else if (receive_flag && !receive_buffer_read) begin
                    // Previous byte unread: hold SCL; a read in this very cycle frees the buffer
                    state <= I2CSE_WAIT_RX;
                  end else begin
                    receive_buffer <= sh;
                    ev_rx_load <= 1'b1;
                    acking <= 1'b1;
                    drive_low <= 1'b1;
                    state <= I2CSE_ACK;
                  end
                end
              endcase
            end
          end
          I2CSE_WAIT_ADR: begin
            // First byte written: release and ACK the address
            if (tx_full) begin
              acking <= 1'b1;
              drive_low <= 1'b1;
              state <= I2CSE_ACK;
            end
          end
          I2CSE_ACK: begin
            if (scl_fall) begin
              drive_low <= 1'b0;
              cnt <= `I2CSE_RST_CNT;
              if (!acking) begin
                // After a NACK wait for stop or restart
                state <= I2CSE_IDLE;
              end else if (tx_mode) begin
                // Move the held byte out and drive its MSB
                sh <= tx_buf;
                tx_full <= transmit_buffer_write;
                ev_move <= 1'b1;
                drive_low <= ~tx_buf[7];
                state <= I2CSE_TXD;
              end else begin
                state <= I2CSE_RECV;
              end
            end
          end
          I2CSE_TXD: begin
            if (scl_fall) begin
              if (cnt == `I2CSE_LAST_BIT) begin
                // Byte done: release SDA for the master's ACK
                drive_low <= 1'b0;
                state <= I2CSE_TXACK;
              end else begin
                cnt <= cnt + 4'h1;
                sh <= {sh[6:0], 1'b0};
                drive_low <= ~sh[6];
              end
            end
          end
          I2CSE_TXACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_q;
            end else if (scl_fall) begin
              cnt <= `I2CSE_RST_CNT;
              if (!master_ack) begin
                // NACK from master: stop or restart follows
                state <= I2CSE_IDLE;
              end else if (tx_full) begin
                sh <= tx_buf;
                tx_full <= transmit_buffer_write;
                ev_move <= 1'b1;
                drive_low <= ~tx_buf[7];
                state <= I2CSE_TXD;
              end else begin
                // Empty buffer: stretch until software writes
                state <= I2CSE_WAIT_TX;
              end
            end
          end
          I2CSE_WAIT_TX: begin
            if (tx_full) begin
              sh <= tx_buf;
              tx_full <= transmit_buffer_write;
              ev_move <= 1'b1;
              drive_low <= ~tx_buf[7];
              state <= I2CSE_TXD;
            end
          end
          I2CSE_WAIT_RX: begin
            if (nack_request) begin
              // Release at once; the unread byte is overwritten
              receive_buffer <= sh;
              ev_rx_load <= 1'b1;
              ev_nack_sent <= 1'b1;
              acking <= 1'b0;
              drive_low <= 1'b0;
              state <= I2CSE_ACK;
            end else if (receive_buffer_read) begin
              receive_buffer <= sh;
              ev_rx_load <= 1'b1;
              acking <= 1'b1;
              drive_low <= 1'b1;
              state <= I2CSE_ACK;
            end
          end
          default: begin
            // Idle: nothing until a start
            state <= I2CSE_IDLE;
          end
        endcase
      end
    end
  end

  // Direction: hardware decides after the address, beats software clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      transmit_direction <= 1'b0;
    end else if (ev_match_rd) begin
      transmit_direction <= 1'b1;
    end else if (ev_match_wr || transmit_direction_clear) begin
      transmit_direction <= 1'b0;
    end
  end

  // Start-match flag, set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_match_flag <= 1'b0;
    end else if (ev_match_rd || ev_match_wr) begin
      start_match_flag <= 1'b1;
    end else if (start_match_clear || sw_reset) begin
      start_match_flag <= 1'b0;
    end
  end

  // Stop-detect flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_detect_flag <= 1'b0;
    end else if (ev_stop) begin
      stop_detect_flag <= 1'b1;
    end else if (stop_detect_clear || sw_reset) begin
      stop_detect_flag <= 1'b0;
    end
  end

  // Transmit request: cleared by a buffer write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      transmit_request_flag <= 1'b0;
    end else if (ev_match_rd || ev_move) begin
      transmit_request_flag <= 1'b1;
    end else if (transmit_buffer_write || sw_reset) begin
      transmit_request_flag <= 1'b0;
    end
  end

  // Receive flag: cleared by a buffer read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      receive_flag <= 1'b0;
    end else if (ev_rx_load) begin
      receive_flag <= 1'b1;
    end else if (receive_buffer_read || sw_reset) begin
      receive_flag <= 1'b0;
    end
  end

  // NACK request stays pending until the NACK is committed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nack_request <= 1'b0;
    end else if (nack_request_set) begin
      nack_request <= 1'b1;
    end else if (ev_nack_sent || sw_reset) begin
      nack_request <= 1'b0;
    end
  end
endmodule

// [hw/i2cse_sync.sv]
`timescale 1ns/1ps
module i2cse_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second
  logic [W-1:0] meta;

  // A zero-width synchroniser has nothing to carry; refuse it at elaboration
  if (W < 1) begin : g_bad_width
    $error("i2cse_sync: W must be at least 1");
  end

  // Two flops; pins idle high so reset to ones avoids a false start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '1;
      q <= '1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [pkg/i2cse_defs.svh]
// Contract
// - Direction follows matched address read/write bit
// - Width select: 0 seven-bit, 1 ten-bit
// - General call answered only when enabled
// - Start-match flag set only on address match
// - Read match: direction, request, stretch until write
// - Buffer-to-shift move sets transmit request again
// - After master ack send next, else stretch
// - Stop ending slave transaction sets stop flag
// - Repeated start returns to address reception
// - Write match: clear direction, auto ack, flag
// - Unread receive buffer stretches until read
// - NACK request answers next acknowledge with NACK
// - NACK during stretch: release, overwrite buffer
// - Ten-bit full address: receiver, match flag
// - Ten-bit read: restart, first byte, direction one
// - Ten-bit first byte 11110, high bits, rw
// - Receiver drives acknowledge on ninth clock
`ifndef I2CSE_DEFS_SVH
`define I2CSE_DEFS_SVH
`define I2CSE_MODE_I2C 2'h3
`define I2CSE_GC_BYTE 8'h00
`define I2CSE_TEN_PREFIX 5'h1e
`define I2CSE_BYTE_BITS 4'h8
`define I2CSE_LAST_BIT 4'h7
`define I2CSE_RST_BYTE 8'h00
`define I2CSE_RST_CNT 4'h0
`endif

// [pkg/i2cse_pkg.sv]
package i2cse_pkg;
  // Engine states, one-hot
  typedef enum logic [7:0] {
    I2CSE_IDLE     = 8'h01,
    I2CSE_RECV     = 8'h02,
    I2CSE_ACK      = 8'h04,
    I2CSE_TXD      = 8'h08,
    I2CSE_TXACK    = 8'h10,
    I2CSE_WAIT_ADR = 8'h20,
    I2CSE_WAIT_TX  = 8'h40,
    I2CSE_WAIT_RX  = 8'h80
  } i2cse_state_e;
  // Which byte of the frame is being received
  typedef enum logic [2:0] {
    I2CSE_ADDR1 = 3'h1,
    I2CSE_ADDR2 = 3'h2,
    I2CSE_DATA  = 3'h4
  } i2cse_phase_e;
endpackage

// [tb/i2cse_master_bfm.sv]
`timescale 1ns/1ps
module i2cse_master_bfm (
  // Resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // Our own open-drain drivers, 1 means released
  output logic scl_m,
  output logic sda_m
);
  // Quarter of a 125 ns bus clock
  localparam realtime Q = 31.25;
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // Raise SCL and honour a stretch, bounded so a stuck slave cannot hang us
  task automatic rise();
    scl_m = 1'b1;
    for (int i = 0; i < 20000 && scl !== 1'b1; i++) #1;
  endtask
  // Start or repeated start: SDA falls while SCL high
  task automatic start();
    sda_m = 1'b1;
    #Q;
    rise();
    #Q;
    sda_m = 1'b0;
    #Q;
    scl_m = 1'b0;
    #Q;
  endtask
  // One bit: data set while SCL low, sampled mid-high
  task automatic bit_xfer(input logic b, output logic r);
    sda_m = b;
    #Q;
    rise();
    #Q;
    r = sda;
    #Q;
    scl_m = 1'b0;
    #Q;
  endtask
  // Byte out MSB first; ack is 1 when the slave pulled SDA low
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then our acknowledge on the ninth clock
  task automatic rbyte(input logic ackit, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(!ackit, r);
    sda_m = 1'b1;
  endtask
  // Stop: SDA rises while SCL high
  task automatic stop();
    sda_m = 1'b0;
    #Q;
    rise();
    #Q;
    sda_m = 1'b1;
    #(2 * Q);
  endtask
endmodule

// [tb/i2cse_slave_sva.sv]
`timescale 1ns/1ps
module i2cse_slave_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sw_reset,
  // Bus pin drivers
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Status and flags
  input wire logic transmit_direction,
  input wire logic start_match_flag,
  input wire logic stop_detect_flag,
  input wire logic transmit_request_flag,
  input wire logic receive_flag,
  // Software strobes
  input wire logic start_match_clear,
  input wire logic stop_detect_clear,
  input wire logic transmit_buffer_write,
  input wire logic receive_buffer_read,
  input wire logic nack_request_set
);
  // One clock domain, so one default clocking and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Read match: direction rises, then request and match flags follow
  sequence s_tx_match;
    $rose(transmit_direction);
  endsequence
  sequence s_tx_ready;
    ##[0:2] (transmit_request_flag && start_match_flag);
  endsequence
  property p_tx_flags;
    s_tx_match |-> s_tx_ready;
  endproperty
  a_tx_flags: assert property (p_tx_flags) else $error("read match without request flag");
  // Pins are only ever pulled low, and SDA is let go while SCL is held
  property p_drive_low;
    scl_out == 1'b0 && sda_out == 1'b0 && !(scl_oe && sda_oe);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("pin driven high or both held");
  // Each releasing access ends a stretch within two clocks
  property p_rel_tx;
    scl_oe && transmit_direction && transmit_buffer_write |-> ##[1:2] !scl_oe;
  endproperty
  a_rel_tx: assert property (p_rel_tx) else $error("stretch kept after write");
  property p_rel_rx;
    scl_oe && !transmit_direction && receive_buffer_read |-> ##[1:2] !scl_oe;
  endproperty
  a_rel_rx: assert property (p_rel_rx) else $error("stretch kept after read");
  property p_rel_nack;
    scl_oe && !transmit_direction && nack_request_set |-> ##[1:2] !scl_oe;
  endproperty
  a_rel_nack: assert property (p_rel_nack) else $error("stretch kept after nack");
  // Flags only fall through their own clear or the soft reset
  property p_hold_start;
    start_match_flag && !start_match_clear && !sw_reset |=> start_match_flag;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("match flag lost");
  property p_hold_stop;
    stop_detect_flag && !stop_detect_clear && !sw_reset |=> stop_detect_flag;
  endproperty
  a_hold_stop: assert property (p_hold_stop) else $error("stop flag lost");
  property p_hold_rx;
    receive_flag && !receive_buffer_read && !sw_reset |=> receive_flag;
  endproperty
  a_hold_rx: assert property (p_hold_rx) else $error("receive flag lost");
  property p_hold_tx;
    transmit_request_flag && !transmit_buffer_write && !sw_reset |=> transmit_request_flag;
  endproperty
  a_hold_tx: assert property (p_hold_tx) else $error("request flag lost");
  // Soft reset held two clocks leaves the bus free and the match and stop flags low
  property p_soft_reset;
    sw_reset ##1 sw_reset |-> !scl_oe && !sda_oe && !start_match_flag && !stop_detect_flag;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not idle");
  // A received byte never raises the flag while transmitting
  property p_rx_dir;
    $rose(receive_flag) |-> !transmit_direction;
  endproperty
  a_rx_dir: assert property (p_rx_dir) else $error("receive flag in transmit");
endmodule
bind i2cse_slave i2cse_slave_sva u_sva (.clk, .reset_n, .sw_reset, .scl_out, .scl_oe, .sda_out, .sda_oe,
  .transmit_direction, .start_match_flag, .stop_detect_flag, .transmit_request_flag, .receive_flag,
  .start_match_clear, .stop_detect_clear, .transmit_buffer_write, .receive_buffer_read, .nack_request_set);

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import i2cse_pkg::*;
  // Strobe slots and own address
  localparam int P_SMC = 0, P_SDC = 1, P_TDC = 2, P_TBW = 3, P_RBR = 4, P_NAK = 5;
  localparam logic [6:0] OWN7 = 7'h35;
  logic clk, reset_n, sw_reset, scl_m, sda_m, scl_out, scl_oe, sda_out, sda_oe;
  logic [1:0] serial_mode_select;
  logic synchronous_mode_bit, master_select, own_address_ten_bit, general_call_respond;
  logic [9:0] own_address_zero;
  logic transmit_direction, start_match_flag, stop_detect_flag, transmit_request_flag, receive_flag;
  logic nack_request, ack;
  logic [7:0] transmit_buffer_data, receive_buffer, d;
  logic [5:0] pl; // Software strobes, one clock each
  int miscompares = 0, num_checks = 0;
  // Pull-ups: a wire is low when anyone pulls it
  wire scl_in = scl_m & !(scl_oe & !scl_out);
  wire sda_in = sda_m & !(sda_oe & !sda_out);
  i2cse_slave DUT (.clk, .reset_n, .sw_reset, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
    .serial_mode_select, .synchronous_mode_bit, .master_select, .own_address_zero, .own_address_ten_bit,
    .general_call_respond, .transmit_direction, .transmit_direction_clear(pl[P_TDC]), .start_match_flag,
    .start_match_clear(pl[P_SMC]), .stop_detect_flag, .stop_detect_clear(pl[P_SDC]), .transmit_request_flag,
    .receive_flag, .transmit_buffer_data, .transmit_buffer_write(pl[P_TBW]), .receive_buffer,
    .receive_buffer_read(pl[P_RBR]), .nack_request_set(pl[P_NAK]), .nack_request);
  i2cse_master_bfm m (.scl(scl_in), .sda(sda_in), .scl_m, .sda_m);
  // 250 MHz module clock
  always #2 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-clock software strobe, launched at the falling edge
  task automatic pulse(input int k, input logic [7:0] wd = 8'h00);
    @(negedge clk);
    transmit_buffer_data = wd;
    pl[k] = 1'b1;
    @(negedge clk);
    pl = '0;
  endtask
  // Wait, bounded, for the slave to stretch SCL
  task automatic wait_oe();
    for (int i = 0; i < 4000 && scl_oe !== 1'b1; i++) @(negedge clk);
    chk(scl_oe, 1'b1);
    // Flags follow the stretch by one clock
    @(negedge clk);
  endtask
  task automatic clr();
    pulse(P_SMC);
    pulse(P_SDC);
    pulse(P_RBR);
  endtask
  // Write transfer, second byte stalls on an unread buffer
  task automatic sc_write();
    m.start();
    m.wbyte({OWN7, 1'b0}, ack);
    chk(ack, 1'b1);
    chk(start_match_flag, 1'b1);
    chk(transmit_direction, 1'b0);
    m.wbyte(8'h5a, ack);
    chk(receive_flag, 1'b1);
    chk(receive_buffer, 8'h5a);
    fork
      m.wbyte(8'hc3, ack);
      begin
        wait_oe();
        chk(receive_buffer, 8'h5a);
        pulse(P_RBR);
      end
    join
    chk(ack, 1'b1);
    chk(receive_buffer, 8'hc3);
    m.stop();
    chk(stop_detect_flag, 1'b1);
    clr();
  endtask
  // Wrong address, general call off, general call on, own address in master mode
  task automatic sc_miss();
    for (int g = 0; g < 4; g++) begin
      @(negedge clk);
      general_call_respond = (g == 2);
      master_select = (g == 3);
      m.start();
      m.wbyte((g == 0) ? {OWN7 ^ 7'h01, 1'b0} : (g == 3) ? {OWN7, 1'b0} : 8'h00, ack);
      chk(ack, g == 2);
      chk(start_match_flag, g == 2);
      m.stop();
      clr();
    end
    @(negedge clk);
    master_select = 1'b0;
  endtask
  // Read transfer: address stretch, buffered byte, empty-buffer stretch
  task automatic sc_read();
    fork
      begin
        m.start();
        m.wbyte({OWN7, 1'b1}, ack);
      end
      begin
        wait_oe();
        chk(transmit_direction, 1'b1);
        chk(transmit_request_flag, 1'b1);
        pulse(P_TBW, 8'ha5);
      end
    join
    chk(ack, 1'b1);
    chk(transmit_request_flag, 1'b1);
    pulse(P_TBW, 8'h3c);
    m.rbyte(1'b1, d);
    chk(d, 8'ha5);
    m.rbyte(1'b1, d);
    chk(d, 8'h3c);
    fork
      m.rbyte(1'b0, d);
      begin
        wait_oe();
        pulse(P_TBW, 8'h96);
      end
    join
    chk(d, 8'h96);
    m.stop();
    chk(stop_detect_flag, 1'b1);
    clr();
  endtask
  // Nack during a stretch, restart, then nack requested ahead
  task automatic sc_nack();
    m.start();
    m.wbyte({OWN7, 1'b0}, ack);
    m.wbyte(8'h11, ack);
    fork
      m.wbyte(8'h22, ack);
      begin
        wait_oe();
        pulse(P_NAK);
      end
    join
    chk(ack, 1'b0);
    chk(receive_buffer, 8'h22);
    m.start();
    m.wbyte({OWN7, 1'b0}, ack);
    chk(ack, 1'b1);
    pulse(P_RBR);
    pulse(P_NAK);
    m.wbyte(8'h33, ack);
    chk(ack, 1'b0);
    chk(receive_buffer, 8'h33);
    chk(nack_request, 1'b0);
    m.stop();
    clr();
  endtask
  // Ten-bit write match, then restart for a read
  task automatic sc_ten();
    @(negedge clk);
    own_address_ten_bit = 1'b1;
    m.start();
    m.wbyte({5'h1e, 2'b10, 1'b0}, ack);
    chk(ack, 1'b1);
    m.wbyte(8'hb5, ack);
    chk(ack, 1'b1);
    chk(start_match_flag, 1'b1);
    chk(transmit_direction, 1'b0);
    pulse(P_SMC);
    fork
      begin
        m.start();
        m.wbyte({5'h1e, 2'b10, 1'b1}, ack);
      end
      begin
        wait_oe();
        pulse(P_TBW, 8'h69);
      end
    join
    chk(start_match_flag, 1'b1);
    chk(transmit_direction, 1'b1);
    m.rbyte(1'b0, d);
    chk(d, 8'h69);
    m.stop();
  endtask
  // Single exit point
  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence; slave mode selected before the engine leaves soft reset
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    sw_reset = 1'b1;
    pl = '0;
    transmit_buffer_data = 8'h00;
    serial_mode_select = 2'h3;
    synchronous_mode_bit = 1'b1;
    master_select = 1'b0;
    own_address_zero = 10'h2b5;
    own_address_ten_bit = 1'b0;
    general_call_respond = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    sw_reset = 1'b0;
    pulse(P_TDC);
    sc_write();
    sc_miss();
    sc_read();
    sc_nack();
    sc_ten();
    give_verdict();
  end
  // Watchdog well past the expected run of about 25 us
  initial begin
    #300000;
    miscompares++;
    give_verdict();
  end
endmodule
